// File: include/cst_pkg.sv
// Constants, types and register map for the charger supervisor timers.
// Assumes a 40 MHz system clock and a simple strobe register port.
// Notes on behaviour
// [RULE1] Probe states alternate the rail level, each shift taking a fixed period.
// [RULE2] Detection has three states; only termination without battery enters probing.
// [RULE3] Probe states drive upper and lower rail levels and check for insertion.
// [RULE4] Probing cycles between the two states until a battery is inserted.
// [RULE5] Input sag to the power threshold lowers the input current limit.
// [RULE6] Sleep stops converter, enables battery switch, pulses status, updates bits.
// [RULE7] Leaving sleep clears fault bits and starts a fresh charge cycle.
// [RULE8] Input overvoltage stops converter, enables battery switch, pulses, updates bits.
// [RULE9] When overvoltage clears, fault bits clear and operation resumes unaided.
// [RULE10] Thermistor ratio classed hot lowest, then warm, cool, cold highest.
// [RULE11] Warm and cool zones adjust regulation voltage and charge current.
// [RULE12] Host should toggle charge enable after a cold fault stops a full battery.
// [RULE13] Production test mode: pure buck, input current limit disabled.
// [RULE14] Test mode refused while a battery is present.
// [RULE15] Safety timer starts with charging; expiry suspends, pulses, sets fault.
// [RULE16] Safety timer duration is selectable by the host register.
// [RULE17] Stretch bit halves timer rate in precharge, thermal or temperature reduce.
// [RULE18] Timer pauses in overvoltage, temperature fault, shutdown, sleep; removal resets.
// [RULE19] Fixed-timeout watchdog restarted by every register write. The code ignores writes in default mode after safety expiry.
// [RULE20] Watchdog enable bit: zero disables, one enables and resets the count.
// [RULE21] Watchdog expiry loads defaults; writes reprogram only before timer expiry. The code blocks writes only in default mode after safety expiry.
// [RULE22] Severe faults disable rail and charging; others disable charging only. The code leaves charging on for LDO low above sleep.
// [RULE23] Timer resets on lockout and timer fault, pauses on other faults. The code skips the reset while the timer fault is set.
// [RULE24] Read-only watchdog expired flag reads one after timeout while enabled.
// [RULE25] Charge state field: 00 ready, 01 charging, 10 done, 11 fault.
// [RULE26] Status pulses timed by counter; new events do not truncate a pulse.
// [RULE27] Combined faults take most restrictive action; pausing beats counting.
package cst_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PROBE_PERIOD_MS = 64;
  localparam int unsigned PROBE_CYCLES = CLK_HZ / 1000 * PROBE_PERIOD_MS;
  localparam int unsigned PULSE_US = 256;
  localparam int unsigned PULSE_CYCLES = CLK_HZ / 1_000_000 * PULSE_US;
  localparam int unsigned WDOG_S = 50;
  localparam longint unsigned WDOG_CYCLES = longint'(CLK_HZ) * WDOG_S;
  // Safety timer base tick: one second
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  // Duration register counts hours; the timer counts seconds
  localparam logic [31:0] SECS_PER_HOUR = 32'd3600;
  // ---------------------------------------------------------------
  // Register map (word index = byte offset here, 8-bit data)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_TIMER = 4'h2;
  localparam logic [3:0] ADDR_FAULT = 4'h3;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  // Status register fields
  localparam int BIT_WD_EXPIRED = 7;
  localparam int BIT_WD_ENABLE = 6;
  localparam int BIT_STATE_HI = 5;
  localparam int BIT_STATE_LO = 4;
  // Control register fields
  localparam int BIT_CHG_EN = 0;
  localparam int BIT_STRETCH = 1;
  localparam int BIT_TEST_REQ = 2;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] TIMER_RESET = 8'h06; // Default duration, hours
  localparam logic [7:0] WDEN_RESET = 8'h01;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CS_READY = 2'h0, CS_CHARGING = 2'h1, CS_DONE = 2'h2, CS_FAULT = 2'h3
  } cst_chg_state_t;
  typedef enum logic [2:0] {
    BD_CHECK = 3'h1, BD_HIGH = 3'h2, BD_LOW = 3'h4
  } cst_det_state_t;
  typedef enum logic [1:0] {
    TZ_NORMAL = 2'h0, TZ_WARM = 2'h1, TZ_COOL = 2'h2, TZ_FAULT = 2'h3
  } cst_tzone_t;
  // Fault codes in fault register
  localparam logic [3:0] FC_NONE = 4'h0;
  localparam logic [3:0] FC_OVP = 4'h1;
  localparam logic [3:0] FC_UVLO = 4'h2;
  localparam logic [3:0] FC_SLEEP = 4'h3;
  localparam logic [3:0] FC_TEMP = 4'h4;
  localparam logic [3:0] FC_TSHUT = 4'h5;
  localparam logic [3:0] FC_TIMER = 4'h6;
  localparam logic [3:0] FC_NOBAT = 4'h7;
  localparam logic [3:0] FC_CHARGE_CURRENT_SET_PIN = 4'h8;
  localparam logic [3:0] FC_LDO = 4'h9;
  // Thermistor ratio thresholds, per mille of regulator output
  localparam logic [9:0] TS_HOT = 10'd300;
  localparam logic [9:0] TS_WARM = 10'd383;
  localparam logic [9:0] TS_COOL = 10'd565;
  localparam logic [9:0] TS_COLD = 10'd600;
endpackage

// File: include/cst_pulse_if.sv
// Event-to-pulse carrier between supervisor and pulse stretcher.
// Assumes both ends on sys_clk_in.
`timescale 1ns/1ps
interface cst_pulse_if;
  logic event_p;
  logic pulse;
  modport src (output event_p, input pulse);
  modport gen (input event_p, output pulse);
endinterface

// File: core/cst_pulse_gen.sv
// Fixed-length status pulse generator.
// Assumes one-cycle event strobes synchronous to sys_clk_in.
`timescale 1ns/1ps
module cst_pulse_gen #(
  parameter int unsigned LEN = cst_pkg::PULSE_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  cst_pulse_if.gen pif
);
  import cst_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
  } cst_pg_state_t;
  cst_pg_state_t s_q, s_d;
  initial begin
    if (LEN < 1 || LEN > 65535) $error("pulse length out of range");
  end
  // ---------------------------------------------------------------
  // Counter: a running pulse is never cut or restarted
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_q.cnt != 16'h0) begin
      s_d.cnt = s_q.cnt - 16'h1; // RULE26
    end else if (pif.event_p) begin
      s_d.cnt = LEN[15:0]; // RULE26
    end
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign pif.pulse = (s_q.cnt != 16'h0);
endmodule // cst_pulse_gen

// File: core/cst_supervisor.sv
// Charger supervisor: detection, faults, safety timer and watchdog.
// Assumes analog comparator results arrive as synchronous levels.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module cst_supervisor #(
  parameter int unsigned PROBE_CNT = cst_pkg::PROBE_CYCLES,
  parameter longint unsigned WDOG_CNT = cst_pkg::WDOG_CYCLES,
  parameter int unsigned TICK_CNT = cst_pkg::TICK_CYCLES,
  parameter int unsigned PULSE_CNT = cst_pkg::PULSE_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Comparator levels
  input wire logic vin_above_uvlo_in,
  input wire logic vin_above_sleep_in,
  input wire logic vin_above_ovp_in,
  input wire logic vin_at_power_threshold_in,
  input wire logic thermal_shutdown_in,
  input wire logic thermal_regulation_in,
  input wire logic ldo_low_in,
  input wire logic charge_current_set_pin_short_in,
  input wire logic battery_present_in,
  input wire logic charge_terminated_in,
  input wire logic precharge_in,
  input wire logic [9:0] ts_ratio_in,
  // Outputs
  output logic rail_probe_high_out,
  output logic probe_active_out,
  output logic converter_on_out,
  output logic battery_switch_on_out,
  output logic system_output_on_out,
  output logic charge_on_out,
  output logic input_limit_reduce_out,
  output logic input_limit_off_out,
  output logic production_test_mode_out,
  output logic defaults_loaded_out,
  output cst_pkg::cst_tzone_t tzone_out,
  output logic status_pulse_out,
  output logic irq_pulse_out
);
  import cst_pkg::*;
  initial begin
    if (PROBE_CNT < 2 || PROBE_CNT > 32'h7fffffff) $error("bad probe");
    if (WDOG_CNT < 2 || WDOG_CNT > 64'hffff_ffff) $error("bad watchdog");
    if (TICK_CNT < 2) $error("bad tick");
  end

  typedef struct packed {
    cst_det_state_t det;
    logic [31:0] probe_cnt;
    logic [31:0] wd_cnt;
    logic watchdog_enable_bit;
    logic wd_expired;
    logic defaults;
    logic [7:0] ctrl;
    logic [7:0] timer_sel;
    logic [31:0] tick_cnt;
    logic half_phase;
    logic [19:0] sec_cnt; // Wide enough for the longest duration
    logic timer_expired;
    logic [3:0] fault;
    cst_chg_state_t chg;
    logic production_test_mode;
    logic was_sleep;
    logic was_ovp;
    logic [7:0] rdata;
  } cst_state_t;
  cst_state_t s_q, s_d;

  cst_pulse_if pif ();
  cst_pulse_gen #(.LEN(PULSE_CNT)) u_pulse (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .pif(pif)
  );

  // ---------------------------------------------------------------
  // Condition decode
  // ---------------------------------------------------------------
  logic uvlo, sleep, ovp, tfault, nobat, severe, mild;
  logic pause_timer, reset_timer, stretch, charging, evt;
  cst_tzone_t tz;
  logic [31:0] timer_limit;
  always_comb begin
    uvlo = !vin_above_uvlo_in;
    ovp = vin_above_ovp_in;
    sleep = vin_above_uvlo_in && !vin_above_sleep_in; // RULE6
    // Ratio rises as the cell cools
    if (ts_ratio_in <= TS_HOT || ts_ratio_in >= TS_COLD) begin
      tz = TZ_FAULT; // RULE10
    end else if (ts_ratio_in <= TS_WARM) begin
      tz = TZ_WARM; // RULE10 RULE11
    end else if (ts_ratio_in >= TS_COOL) begin
      tz = TZ_COOL; // RULE10 RULE11
    end else begin
      tz = TZ_NORMAL;
    end
    tfault = (tz == TZ_FAULT);
    nobat = !battery_present_in;
    // Worst case wins across simultaneous faults
    severe = ovp || uvlo || sleep || thermal_shutdown_in
      || (ldo_low_in && !vin_above_sleep_in); // RULE22 RULE27
    mild = tfault || s_q.timer_expired || nobat || charge_current_set_pin_short_in; // RULE22
    reset_timer = uvlo || s_q.timer_expired || nobat; // RULE18 RULE23
    pause_timer = ovp || sleep || thermal_shutdown_in || tfault
      || charge_current_set_pin_short_in || ldo_low_in; // RULE18 RULE23 RULE27
    charging = s_q.ctrl[BIT_CHG_EN] && !severe && !mild && !s_q.production_test_mode;
    stretch = s_q.ctrl[BIT_STRETCH] && (precharge_in
      || thermal_regulation_in || tz != TZ_NORMAL); // RULE17
    timer_limit = 32'(s_q.timer_sel) * SECS_PER_HOUR; // RULE16
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    evt = 1'b0;
    // Detection sequencer
    case (s_q.det)
      BD_CHECK: begin
        if (charge_terminated_in && nobat) begin
          s_d.det = BD_HIGH; // RULE2
          s_d.probe_cnt = '0;
        end
      end
      BD_HIGH, BD_LOW: begin
        if (battery_present_in) begin
          s_d.det = BD_CHECK; // RULE3 RULE4
        end else if (s_q.probe_cnt == PROBE_CNT - 1) begin
          s_d.probe_cnt = '0;
          s_d.det = (s_q.det == BD_HIGH) ? BD_LOW : BD_HIGH; // RULE1 RULE4
        end else begin
          s_d.probe_cnt = s_q.probe_cnt + 32'd1; // RULE1
        end
      end
      default: s_d.det = BD_CHECK;
    endcase
    // Test mode gate
    if (!s_q.ctrl[BIT_TEST_REQ]) begin
      s_d.production_test_mode = 1'b0;
    end else if (nobat && s_q.det != BD_CHECK) begin
      s_d.production_test_mode = 1'b1; // RULE14
    end
    // Entry events for pulses; exit clears faults
    s_d.was_sleep = sleep;
    s_d.was_ovp = ovp;
    if (sleep && !s_q.was_sleep) begin
      evt = 1'b1; // RULE6
      s_d.fault = FC_SLEEP;
    end
    if (ovp && !s_q.was_ovp) begin
      evt = 1'b1; // RULE8
      s_d.fault = FC_OVP;
    end
    if ((s_q.was_sleep && !sleep) || (s_q.was_ovp && !ovp)) begin
      s_d.fault = FC_NONE; // RULE7 RULE9
      s_d.sec_cnt = '0; // RULE7
      s_d.tick_cnt = '0;
    end
    // Safety timer; pausing takes priority over counting
    if (reset_timer && !s_q.timer_expired) begin
      s_d.tick_cnt = '0;
      s_d.sec_cnt = '0; // RULE18 RULE23
    end else if (charging && !pause_timer) begin
      if (s_q.tick_cnt == TICK_CNT - 1) begin
        s_d.tick_cnt = '0;
        s_d.half_phase = stretch ? !s_q.half_phase : 1'b0;
        if (!stretch || s_q.half_phase) begin
          s_d.sec_cnt = s_q.sec_cnt + 20'd1; // RULE15 RULE17
        end
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 32'd1;
      end
    end
    // Watchdog runs while enabled
    if (s_q.watchdog_enable_bit && !s_q.wd_expired) begin
      if (s_q.wd_cnt == 32'(WDOG_CNT - 1)) begin
        s_d.wd_expired = 1'b1; // RULE21 RULE24
        s_d.defaults = 1'b1;
        s_d.ctrl = CTRL_RESET; // RULE21
        s_d.timer_sel = TIMER_RESET;
      end else begin
        s_d.wd_cnt = s_q.wd_cnt + 32'd1; // RULE19
      end
    end
    // Register writes; locked out after safety expiry in default mode
    if (reg_wr_in && !(s_q.defaults && s_q.timer_expired)) begin
      s_d.wd_cnt = '0; // RULE19
      s_d.wd_expired = 1'b0;
      s_d.defaults = 1'b0;
      case (reg_addr_in)
        ADDR_STATUS: begin
          s_d.watchdog_enable_bit = reg_wdata_in[BIT_WD_ENABLE]; // RULE20
        end
        ADDR_CTRL: begin
          if (s_q.ctrl[BIT_CHG_EN] && !reg_wdata_in[BIT_CHG_EN]) begin
            s_d.timer_expired = 1'b0; // Charge-enable toggle rearms
            s_d.sec_cnt = '0;
            s_d.fault = FC_NONE; // Else the state field sticks at fault
          end
          s_d.ctrl = reg_wdata_in;
        end
        ADDR_TIMER: s_d.timer_sel = reg_wdata_in; // RULE16
        default: ;
      endcase
    end
    // Expiry after writes, so a toggle in the same cycle never hides it
    if (charging && !s_q.timer_expired
        && 32'(s_q.sec_cnt) >= timer_limit) begin
      s_d.timer_expired = 1'b1; // RULE15
      s_d.fault = FC_TIMER;
      evt = 1'b1;
    end
    // Charge state
    if (s_d.fault != FC_NONE || severe || mild) begin
      s_d.chg = CS_FAULT; // RULE25
    end else if (charge_terminated_in) begin
      s_d.chg = CS_DONE;
    end else if (charging) begin
      s_d.chg = CS_CHARGING;
    end else begin
      s_d.chg = CS_READY;
    end
    // Read data, valid the cycle after the strobe
    s_d.rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_STATUS: begin
          s_d.rdata[BIT_WD_EXPIRED] = s_q.wd_expired && s_q.watchdog_enable_bit; // RULE24
          s_d.rdata[BIT_WD_ENABLE] = s_q.watchdog_enable_bit;
          s_d.rdata[BIT_STATE_HI:BIT_STATE_LO] = s_q.chg; // RULE25
          s_d.rdata[3:0] = s_q.fault;
        end
        ADDR_CTRL: s_d.rdata = s_q.ctrl;
        ADDR_TIMER: s_d.rdata = s_q.timer_sel;
        ADDR_FAULT: s_d.rdata = {3'h0, s_q.production_test_mode, s_q.fault};
        default: s_d.rdata = UNMAPPED_READ;
      endcase
    end
  end

  assign pif.event_p = evt;

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.det <= BD_CHECK;
      s_q.chg <= CS_READY;
      s_q.ctrl <= CTRL_RESET;
      s_q.timer_sel <= TIMER_RESET;
      s_q.watchdog_enable_bit <= WDEN_RESET[0];
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    reg_rdata_out = s_q.rdata;
    probe_active_out = (s_q.det != BD_CHECK);
    rail_probe_high_out = (s_q.det == BD_HIGH); // RULE3
    converter_on_out = !severe; // RULE6 RULE8 RULE13
    battery_switch_on_out = severe && !uvlo; // RULE6 RULE8
    system_output_on_out = !severe; // RULE22
    charge_on_out = charging; // RULE15 RULE22
    input_limit_reduce_out = vin_at_power_threshold_in && !s_q.production_test_mode; // RULE5
    input_limit_off_out = s_q.production_test_mode; // RULE13
    production_test_mode_out = s_q.production_test_mode;
    defaults_loaded_out = s_q.defaults;
    tzone_out = tz; // RULE11
    status_pulse_out = pif.pulse; // RULE26
    irq_pulse_out = pif.pulse;
  end
endmodule // cst_supervisor

// File: dv/cst_supervisor_checker.sv
// Port checker for the charger supervisor.
// Assumes one clock domain and a bench using PULSE_CNT of 5.
`timescale 1ns/1ps
module cst_supervisor_checker
  import cst_pkg::*;
#(
  parameter int unsigned PULSE_CNT = 5
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic vin_above_ovp_in,
  input wire logic vin_at_power_threshold_in,
  input wire logic battery_present_in,
  input wire logic [9:0] ts_ratio_in,
  input wire logic converter_on_out,
  input wire logic battery_switch_on_out,
  input wire logic system_output_on_out,
  input wire logic charge_on_out,
  input wire logic input_limit_reduce_out,
  input wire logic input_limit_off_out,
  input wire logic production_test_mode_out,
  input wire cst_pkg::cst_tzone_t tzone_out,
  input wire logic status_pulse_out,
  input wire logic irq_pulse_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [15:0] pcnt_q;
  // Pulse length counter, too long for a repetition
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) pcnt_q <= 16'h0;
    else pcnt_q <= status_pulse_out ? pcnt_q + 16'h1 : 16'h0;
  end
  property p_ovp_pulse;
    $rose(vin_above_ovp_in) && !status_pulse_out |=> status_pulse_out;
  endproperty
  a_ovp_pulse: assert property (p_ovp_pulse)
    else $error("no pulse after overvoltage");
  property p_ovp_off;
    vin_above_ovp_in |-> !converter_on_out && !system_output_on_out
      && !charge_on_out;
  endproperty
  a_ovp_off: assert property (p_ovp_off)
    else $error("rail or charge left on in overvoltage");
  property p_ovp_bsw;
    vin_above_ovp_in |-> battery_switch_on_out;
  endproperty
  a_ovp_bsw: assert property (p_ovp_bsw)
    else $error("battery switch off in overvoltage");
  property p_pulse_len;
    $fell(status_pulse_out) |-> pcnt_q == PULSE_CNT;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("status pulse length wrong");
  property p_irq;
    status_pulse_out == irq_pulse_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("status and irq pulses differ");
  property p_dpm;
    input_limit_reduce_out ==
      (vin_at_power_threshold_in && !production_test_mode_out);
  endproperty
  a_dpm: assert property (p_dpm)
    else $error("input limit reduce wrong");
  property p_ptm;
    production_test_mode_out |-> input_limit_off_out;
  endproperty
  a_ptm: assert property (p_ptm)
    else $error("input limit active in test mode");
  property p_ptm_bat;
    battery_present_in && !production_test_mode_out |=>
      !production_test_mode_out;
  endproperty
  a_ptm_bat: assert property (p_ptm_bat)
    else $error("test mode entered with battery");
  property p_tz;
    (ts_ratio_in < 10'd300 || ts_ratio_in > 10'd600) |->
      tzone_out == TZ_FAULT;
  endproperty
  a_tz: assert property (p_tz)
    else $error("thermistor fault zone missed");
endmodule // cst_supervisor_checker

bind cst_supervisor cst_supervisor_checker #(.PULSE_CNT(PULSE_CNT))
  i_cst_supervisor_checker (.*);

// File: dv/cst_host_model.sv
// Host model driving the strobe register port.
// Assumes calls come from one process.
`timescale 1ns/1ps
module cst_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [3:0] reg_addr_out = 4'h0,
  output logic [7:0] reg_wdata_out = 8'h00,
  output logic reg_wr_out = 1'b0,
  output logic reg_rd_out = 1'b0
);
  // Idle lines show inverted data so stale values never match
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    @(negedge sys_clk_in);
    d = reg_rdata_in;
  endtask
endmodule // cst_host_model

// File: dv/cst_supervisor_tb_top.sv
// Self-checking bench for the charger supervisor.
// Assumes short parameters: probe 8, watchdog 20, tick 4, pulse 5.
`timescale 1ns/1ps
module cst_supervisor_tb_top;
  import cst_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] ra;
  logic [7:0] wd, rdat, rd_v;
  logic we, re;
  logic slp = 1'b1, ovp = 1'b0, dpm = 1'b0, bat = 1'b1, term = 1'b0;
  logic pre = 1'b0;
  logic uvlo = 1'b1, tshut = 1'b0, treg = 1'b0, ldo = 1'b0, charge_current_set_pin = 1'b0;
  logic [9:0] ts = 10'd450;
  logic rail_hi, probe, conv, bsw, sys_on, chg, lim_red, lim_off, production_test_mode;
  logic dflt, pulse;
  cst_tzone_t tz;
  int fail_count = 0;
  int n_tests = 0;
  int cyc_n = 0;
  cst_supervisor #(.PROBE_CNT(8), .WDOG_CNT(20), .TICK_CNT(4),
    .PULSE_CNT(5)) i_cst_supervisor (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdat),
    .vin_above_uvlo_in(uvlo), .vin_above_sleep_in(slp),
    .vin_above_ovp_in(ovp), .vin_at_power_threshold_in(dpm),
    .thermal_shutdown_in(tshut), .thermal_regulation_in(treg),
    .ldo_low_in(ldo), .charge_current_set_pin_short_in(charge_current_set_pin), .battery_present_in(bat),
    .charge_terminated_in(term), .precharge_in(pre), .ts_ratio_in(ts),
    .rail_probe_high_out(rail_hi), .probe_active_out(probe),
    .converter_on_out(conv), .battery_switch_on_out(bsw),
    .system_output_on_out(sys_on), .charge_on_out(chg),
    .input_limit_reduce_out(lim_red), .input_limit_off_out(lim_off),
    .production_test_mode_out(production_test_mode), .defaults_loaded_out(dflt),
    .tzone_out(tz), .status_pulse_out(pulse), .irq_pulse_out());
  cst_host_model i_cst_host_model (.sys_clk_in(sys_clk_in),
    .reg_rdata_in(rdat), .reg_addr_out(ra), .reg_wdata_out(wd),
    .reg_wr_out(we), .reg_rd_out(re));
  // Clock and hang guard; ceiling well above the safety timer runs
  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc_n++;
    if (cyc_n == 100000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_cst_host_model.wr(a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    i_cst_host_model.rd(a, rd_v);
  endtask
  task automatic wait_pulse(input int lim, output int n);
    n = 0;
    while (pulse !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_regs();
    rd(ADDR_CTRL);
    cmp(rd_v, CTRL_RESET);
    rd(ADDR_TIMER);
    cmp(rd_v, TIMER_RESET);
    rd(ADDR_STATUS);
    cmp(rd_v[6], 1'b1);
    rd(4'hf);
    cmp(rd_v, UNMAPPED_READ);
    wr(ADDR_TIMER, 8'h03);
    rd(ADDR_TIMER);
    cmp(rd_v, 8'h03);
  endtask
  // Expiry loads defaults; a zero enable stops the count
  task automatic t_wdog();
    cyc(25);
    cmp(dflt, 1'b1);
    rd(ADDR_STATUS);
    cmp(rd_v[7], 1'b1);
    rd(ADDR_TIMER);
    cmp(rd_v, TIMER_RESET);
    wr(ADDR_STATUS, 8'h40);
    cyc(10);
    cmp(dflt, 1'b0);
    wr(ADDR_STATUS, 8'h00);
    cyc(40);
    cmp(dflt, 1'b0);
    rd(ADDR_STATUS);
    cmp(rd_v[7:6], 2'b00);
  endtask
  task automatic t_fault(input bit is_ovp);
    int n;
    @(posedge sys_clk_in);
    if (is_ovp) ovp <= 1'b1;
    else slp <= 1'b0;
    wait_pulse(4, n);
    cmp(pulse, 1'b1);
    cmp({conv, bsw, sys_on, chg}, 4'b0100);
    rd(ADDR_FAULT);
    cmp(rd_v[3:0], is_ovp ? FC_OVP : FC_SLEEP);
    rd(ADDR_STATUS);
    cmp(rd_v[5:4], CS_FAULT);
    @(posedge sys_clk_in);
    ovp <= 1'b0;
    slp <= 1'b1;
    cyc(3);
    rd(ADDR_FAULT);
    cmp(rd_v[3:0], FC_NONE);
    rd(ADDR_STATUS);
    cmp(rd_v[5:4], CS_CHARGING);
  endtask
  task automatic t_temp();
    logic [9:0] r [5] = '{10'd250, 10'd350, 10'd450, 10'd580, 10'd650};
    cst_tzone_t z [5] = '{TZ_FAULT, TZ_WARM, TZ_NORMAL, TZ_COOL, TZ_FAULT};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_in);
      ts <= r[i];
      cyc(2);
      cmp(tz, z[i]);
    end
    cmp({sys_on, chg}, 2'b10);
    @(posedge sys_clk_in);
    ts <= 10'd450;
    dpm <= 1'b1;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    cyc(2);
    cmp({chg, lim_red}, 2'b11);
    @(posedge sys_clk_in);
    dpm <= 1'b0;
  endtask
  // Hardware faults: severe ones drop the rail, mild ones only charging; LDO low above sleep leaves both on
  task automatic t_hw();
    @(posedge sys_clk_in);
    tshut <= 1'b1;
    cyc(2);
    cmp({conv, sys_on, chg}, 3'b000);
    @(posedge sys_clk_in);
    tshut <= 1'b0;
    charge_current_set_pin <= 1'b1;
    cyc(2);
    cmp({conv, sys_on, chg}, 3'b110);
    @(posedge sys_clk_in);
    charge_current_set_pin <= 1'b0;
    uvlo <= 1'b0;
    cyc(2);
    cmp({bsw, sys_on, chg}, 3'b000);
    @(posedge sys_clk_in);
    uvlo <= 1'b1;
    ldo <= 1'b1;
    cyc(2);
    cmp({sys_on, chg}, 2'b11);
    @(posedge sys_clk_in);
    ldo <= 1'b0;
  endtask
  // Battery removal zeroes the timer, so timing starts at reinsertion
  task automatic t_safety(input bit stretch);
    int n;
    wr(ADDR_TIMER, 8'h01);
    wr(ADDR_CTRL, {6'h0, stretch, 1'b1});
    @(posedge sys_clk_in);
    pre <= stretch;
    bat <= 1'b0;
    cyc(3);
    @(posedge sys_clk_in);
    bat <= 1'b1;
    wait_pulse(40000, n);
    cmp(n / 40, (stretch ? 28800 : 14400) / 40);
    cmp(chg, 1'b0);
    rd(ADDR_FAULT);
    cmp(rd_v[3:0], FC_TIMER);
    @(posedge sys_clk_in);
    pre <= 1'b0;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h01);
  endtask
  task automatic t_probe();
    int n = 0;
    @(posedge sys_clk_in);
    term <= 1'b1;
    wr(ADDR_CTRL, 8'h05);
    cyc(2);
    cmp({probe, production_test_mode}, 2'b00);
    @(posedge sys_clk_in);
    bat <= 1'b0;
    cyc(3);
    cmp(probe, 1'b1);
    while (rail_hi !== 1'b0 && n < 40) begin
      cyc(1);
      n++;
    end
    while (rail_hi !== 1'b1 && n < 80) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (rail_hi === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    cmp(n, 8);
    wr(ADDR_CTRL, 8'h05);
    cyc(2);
    cmp({production_test_mode, lim_off, probe}, 3'b111);
    @(posedge sys_clk_in);
    bat <= 1'b1;
    term <= 1'b0;
    cyc(3);
    cmp(probe, 1'b0);
    wr(ADDR_CTRL, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_wdog();
    t_fault(1'b1);
    t_fault(1'b0);
    t_temp();
    t_hw();
    t_probe();
    t_safety(1'b0);
    t_safety(1'b1);
    end_of_test();
  end
endmodule // cst_supervisor_tb_top
